// ===== src/frac_div_pkg.sv
// Overview of operation
// - rf divider gives one pulse per cycle; rise to detector, fall steps modulator
// - second order modulator works on 23-bit fraction, 22-bit effective resolution
// - fraction lsb forced to one; upper 22 bits come from the setting
// - forced lsb gives maximum sequence length of 2 times 2^23 cycles
// - 2-bit correction added to whole part; ratio spans whole-1 to whole+2
// - if divider divides by 128 to 16383, bits 21:8 of if_setup_word
// - reference divider divides by tcxo_scale 4..1023, ref_setup_word bits 21:12
// - tap_choice, if_setup_word bits 2:0, picks one of five reference taps
// - rf detector reference comes straight from the reference buffer
// - new whole part waits pending until frac_setup_word is loaded
// - loading a new fraction does not reset the modulator state
// - reset loads default setup words and clears the modulator to zero
package frac_div_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_FRAC   = 8'h00;
   localparam logic [7:0] OFS_REF    = 8'h04;
   localparam logic [7:0] OFS_IF     = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_ACC    = 8'h10;

   // field positions
   localparam int FRAC_LSB  = 0;   // 22-bit fraction at 21:0
   localparam int WHOLE_LSB = 0;   // 9-bit whole part at 8:0
   localparam int SCALE_LSB = 12;  // tcxo_scale at 21:12
   localparam int IFR_LSB   = 8;   // if ratio at 21:8
   localparam int TAP_LSB   = 0;   // tap_choice at 2:0
   localparam int CODE_LSB  = 16;  // status: correction code

   // widths
   localparam int FRAC_W  = 22;
   localparam int MOD_W   = 23;
   localparam int WHOLE_W = 9;
   localparam int SCALE_W = 10;
   localparam int IFR_W   = 14;
   localparam int CNT_W   = 14;

   // values after reset
   localparam logic [21:0] RST_FRAC  = 22'h00_0000;
   localparam logic [8:0]  RST_WHOLE = 9'h021;
   localparam logic [9:0]  RST_SCALE = 10'h004;
   localparam logic [13:0] RST_IFR   = 14'h0080;
   localparam logic [2:0]  RST_TAP   = 3'h0;
   localparam logic [22:0] RST_ACC   = 23'h00_0000;

   // reference taps
   typedef enum logic [2:0] {
      TAP_DIV1 = 3'h0,
      TAP_DIV2 = 3'h1,
      TAP_DIV4 = 3'h2,
      TAP_DIV8 = 3'h3,
      TAP_RAW  = 3'h4
   } tap_t;
endpackage

// ===== src/sd_mod2.sv
`timescale 1ns/1ps
// two cascaded wrapping accumulators; code = correction + 1 (0..3)
module sd_mod2 (
   input  wire logic        core_clk,
   input  wire logic        srst,
   input  wire logic        step,
   input  wire logic [22:0] frac_value,
   output logic      [1:0]  corr_code,
   output logic      [22:0] acc_state
);
   logic [22:0] acc1;
   logic [22:0] acc2;
   logic        c2_prev;
   logic [23:0] sum1;
   logic [23:0] sum2;

   // carries out of each stage; wrap is modulo 2^23
   assign sum1 = {1'b0, acc1} + {1'b0, frac_value};
   assign sum2 = {1'b0, acc2} + {1'b0, sum1[22:0]};
   assign acc_state = acc1;

   // state only moves on a step, never on a new fraction
   always_ff @(posedge core_clk) begin
      if (srst) begin
         acc1    <= frac_div_pkg::RST_ACC;
         acc2    <= frac_div_pkg::RST_ACC;
         c2_prev <= 1'b0;
         corr_code <= 2'h1;
      end else if (step) begin
         acc1    <= sum1[22:0];
         acc2    <= sum2[22:0];
         c2_prev <= sum2[23];
         // c1 + c2 - c2_prev spans -1..+2, offset by one
         corr_code <= {1'b0, sum1[23]} + {1'b0, sum2[23]}
                      + {1'b0, ~c2_prev};
      end
   end
endmodule

// ===== src/frac_div_core.sv
`timescale 1ns/1ps
// rf fractional, if integer and reference dividers with apb setup
module frac_div_core (
   input  wire logic        core_clk,
   input  wire logic        srst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        rf_vco_tick,
   input  wire logic        if_vco_tick,
   input  wire logic        ref_tick,
   output logic             rf_div_edge,
   output logic             if_div_edge,
   output logic             rf_ref_edge,
   output logic             if_ref_edge
);
   // setup words
   logic [21:0] frac_setup;
   logic [8:0]  whole_pending;
   logic [8:0]  whole_part_value;
   logic [9:0]  tcxo_scale;
   logic [13:0] if_ratio;
   logic [2:0]  tap_choice;

   // divider state
   logic [13:0] rf_cnt;
   logic [13:0] if_cnt;
   logic [13:0] ref_cnt;
   logic [2:0]  tap_cnt;
   logic        rf_div_prev;
   logic        ref_div_pulse;
   logic        ref_raw_d;

   // modulator
   logic [22:0] frac_value;
   logic [1:0]  corr_code;
   logic [22:0] acc_state;
   logic        mod_step;
   logic [13:0] rf_ratio;

   // apb decode
   logic        wr_take;
   logic        rd_setup;
   logic        addr_ok;
   logic [31:0] next_rdata;

   // counter steps down; returns reload value at terminal count
   function automatic logic [13:0] div_next(input logic [13:0] cnt,
                                            input logic [13:0] ratio);
      if (cnt <= 14'h0001) begin
         div_next = ratio;
      end else begin
         div_next = cnt - 14'h0001;
      end
   endfunction

   function automatic logic div_done(input logic [13:0] cnt);
      div_done = (cnt <= 14'h0001);
   endfunction

   // ---------------- apb slave ----------------
   assign wr_take  = psel & penable & pready & pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign addr_ok  = (paddr == frac_div_pkg::OFS_FRAC)
                   | (paddr == frac_div_pkg::OFS_REF)
                   | (paddr == frac_div_pkg::OFS_IF)
                   | (paddr == frac_div_pkg::OFS_STATUS)
                   | (paddr == frac_div_pkg::OFS_ACC);

   // read mux; reserved bits read zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      case (paddr)
         frac_div_pkg::OFS_FRAC: begin
            next_rdata[frac_div_pkg::FRAC_LSB +: frac_div_pkg::FRAC_W] =
               frac_setup;
         end
         frac_div_pkg::OFS_REF: begin
            next_rdata[frac_div_pkg::SCALE_LSB +: frac_div_pkg::SCALE_W] =
               tcxo_scale;
            next_rdata[frac_div_pkg::WHOLE_LSB +: frac_div_pkg::WHOLE_W] =
               whole_pending;
         end
         frac_div_pkg::OFS_IF: begin
            next_rdata[frac_div_pkg::IFR_LSB +: frac_div_pkg::IFR_W] =
               if_ratio;
            next_rdata[frac_div_pkg::TAP_LSB +: 3] = tap_choice;
         end
         frac_div_pkg::OFS_STATUS: begin
            next_rdata[frac_div_pkg::CODE_LSB +: 2] = corr_code;
            next_rdata[frac_div_pkg::WHOLE_LSB +: frac_div_pkg::WHOLE_W] =
               whole_part_value;
         end
         frac_div_pkg::OFS_ACC: begin
            next_rdata[frac_div_pkg::MOD_W - 1:0] = acc_state;
         end
         default: begin
            next_rdata = 32'h0000_0000;
         end
      endcase
   end

   // one wait-free access phase: ready rises the cycle after setup
   always_ff @(posedge core_clk) begin
      if (srst) begin
         pready  <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
      end
   end

   // error flags an unmapped offset in the same access cycle
   always_ff @(posedge core_clk) begin
      if (srst) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= psel & ~penable & ~addr_ok;
      end
   end

   // read data captured in setup, held through access
   always_ff @(posedge core_clk) begin
      if (srst) begin
         prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata <= next_rdata;
      end
   end

   // ---------------- setup words ----------------
   // whole part waits until the fraction is written, so the pair
   // never shows a false ratio in between
   always_ff @(posedge core_clk) begin
      if (srst) begin
         frac_setup       <= frac_div_pkg::RST_FRAC;
         whole_pending    <= frac_div_pkg::RST_WHOLE;
         whole_part_value <= frac_div_pkg::RST_WHOLE;
         tcxo_scale       <= frac_div_pkg::RST_SCALE;
         if_ratio         <= frac_div_pkg::RST_IFR;
         tap_choice       <= frac_div_pkg::RST_TAP;
      end else if (wr_take) begin
         case (paddr)
            frac_div_pkg::OFS_FRAC: begin
               frac_setup <= pwdata[frac_div_pkg::FRAC_LSB +:
                                    frac_div_pkg::FRAC_W];
               whole_part_value <= whole_pending;
            end
            frac_div_pkg::OFS_REF: begin
               whole_pending <= pwdata[frac_div_pkg::WHOLE_LSB +:
                                       frac_div_pkg::WHOLE_W];
               tcxo_scale <= pwdata[frac_div_pkg::SCALE_LSB +:
                                    frac_div_pkg::SCALE_W];
            end
            frac_div_pkg::OFS_IF: begin
               if_ratio <= pwdata[frac_div_pkg::IFR_LSB +:
                                  frac_div_pkg::IFR_W];
               tap_choice <= pwdata[frac_div_pkg::TAP_LSB +: 3];
            end
            // read-only and unmapped offsets change nothing
            default: begin
               frac_setup <= frac_setup;
            end
         endcase
      end
   end

   // ---------------- rf fractional divider ----------------
   // lsb forced high so every sequence runs full length
   assign frac_value = {frac_setup, 1'b1};

   // momentary ratio whole-1 .. whole+2 from the offset code
   assign rf_ratio = {5'h00, whole_part_value} + {12'h000, corr_code}
                   - 14'h0001;

   // modulator steps on the falling edge of the divider pulse
   assign mod_step = rf_div_prev & ~rf_div_edge;

   sd_mod2 u_mod (
      .core_clk   (core_clk),
      .srst       (srst),
      .step       (mod_step),
      .frac_value (frac_value),
      .corr_code  (corr_code),
      .acc_state  (acc_state)
   );

   // no reset path from a fraction load into the modulator
   // keeps the sequence continuous across retuning

   // one pulse per divide cycle, one core cycle wide
   always_ff @(posedge core_clk) begin
      if (srst) begin
         rf_cnt      <= 14'h0001;
         rf_div_edge <= 1'b0;
      end else begin
         rf_div_edge <= rf_vco_tick & div_done(rf_cnt);
         // ratio with the fresh code is taken only at reload
         if (rf_vco_tick) begin
            rf_cnt <= div_next(rf_cnt, rf_ratio);
         end
      end
   end

   // delayed copy finds the falling edge of the pulse
   always_ff @(posedge core_clk) begin
      if (srst) begin
         rf_div_prev <= 1'b0;
      end else begin
         rf_div_prev <= rf_div_edge;
      end
   end

   // ---------------- if integer divider ----------------
   always_ff @(posedge core_clk) begin
      if (srst) begin
         if_cnt      <= 14'h0001;
         if_div_edge <= 1'b0;
      end else begin
         if_div_edge <= if_vco_tick & div_done(if_cnt);
         // new ratio lands at reload, never mid-count
         if (if_vco_tick) begin
            if_cnt <= div_next(if_cnt, if_ratio);
         end
      end
   end

   // ---------------- reference divider chain ----------------
   // programmable stage then a 3-bit binary counter for the taps
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ref_cnt       <= 14'h0001;
         ref_div_pulse <= 1'b0;
      end else begin
         ref_div_pulse <= ref_tick & div_done(ref_cnt);
         // scale is read at reload, so a change lands next period
         if (ref_tick) begin
            ref_cnt <= div_next(ref_cnt, {4'h0, tcxo_scale});
         end
      end
   end

   // binary counter behind the divider feeds the /2 /4 /8 taps
   always_ff @(posedge core_clk) begin
      if (srst) begin
         tap_cnt <= 3'h0;
      end else if (ref_div_pulse) begin
         tap_cnt <= tap_cnt + 3'h1;
      end
   end

   // raw tick delayed to line up with the divided pulse
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ref_raw_d <= 1'b0;
      end else begin
         ref_raw_d <= ref_tick;
      end
   end

   // rf detector sees the buffered reference, undivided
   always_ff @(posedge core_clk) begin
      if (srst) begin
         rf_ref_edge <= 1'b0;
      end else begin
         rf_ref_edge <= ref_tick;
      end
   end

   // tap select; unused codes fall back to the divider output
   always_ff @(posedge core_clk) begin
      if (srst) begin
         if_ref_edge <= 1'b0;
      end else begin
         case (tap_choice)
            frac_div_pkg::TAP_DIV1: begin
               if_ref_edge <= ref_div_pulse;
            end
            frac_div_pkg::TAP_DIV2: begin
               if_ref_edge <= ref_div_pulse & tap_cnt[0];
            end
            frac_div_pkg::TAP_DIV4: begin
               if_ref_edge <= ref_div_pulse & (&tap_cnt[1:0]);
            end
            frac_div_pkg::TAP_DIV8: begin
               if_ref_edge <= ref_div_pulse & (&tap_cnt);
            end
            // raw tap bypasses both divider and counter
            frac_div_pkg::TAP_RAW: begin
               if_ref_edge <= ref_raw_d;
            end
            default: begin
               if_ref_edge <= ref_div_pulse;
            end
         endcase
      end
   end
endmodule

// ===== testbench/fdc_assertions.sv
`timescale 1ns/1ps
// timing watcher on the core's bus and divider ports
module fdc_checker (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic rf_vco_tick,
   input wire logic if_vco_tick,
   input wire logic ref_tick,
   input wire logic rf_div_edge,
   input wire logic if_div_edge,
   input wire logic rf_ref_edge
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   // rf detector gets the buffer tick one cycle late, never divided
   a_ref_pass: assert property (ref_tick |=> rf_ref_edge)
      else $error("rf reference edge missing");
   a_ref_quiet: assert property (!ref_tick |=> !rf_ref_edge)
      else $error("rf reference edge without tick");
   // bus answers exactly one cycle after setup and at no other time
   a_ready_next: assert property (psel && !penable |=> pready)
      else $error("ready late");
   a_ready_cause: assert property (pready |-> $past(psel) && !$past(penable))
      else $error("ready without setup");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("error outside access");
   // divider edges follow a counted tick by one cycle, one cycle wide
   a_rf_tick: assert property (rf_div_edge |-> $past(rf_vco_tick))
      else $error("rf edge without tick");
   a_rf_single: assert property (rf_div_edge |=> !rf_div_edge)
      else $error("rf edge too wide");
   a_if_tick: assert property (if_div_edge |-> $past(if_vco_tick))
      else $error("if edge without tick");
   a_if_single: assert property (if_div_edge |=> !if_div_edge)
      else $error("if edge too wide");
endmodule

bind frac_div_core fdc_checker chk_u (
   .core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .rf_vco_tick(rf_vco_tick),
   .if_vco_tick(if_vco_tick), .ref_tick(ref_tick),
   .rf_div_edge(rf_div_edge), .if_div_edge(if_div_edge),
   .rf_ref_edge(rf_ref_edge)
);

// ===== testbench/synth_far_model.sv
`timescale 1ns/1ps
// prescaler tick source and phase detector period counter
module synth_far_model (
   input  wire logic core_clk,
   input  wire logic srst,
   input  wire logic en,
   input  wire logic rf_div_edge,
   input  wire logic if_div_edge,
   input  wire logic if_ref_edge,
   output logic      rf_vco_tick,
   output logic      if_vco_tick,
   output logic      ref_tick,
   output int        rat [3],
   output int        num [3]
);
   logic       ph;
   logic [2:0] e;
   int         cnt [3];

   assign e = {if_ref_edge, if_div_edge, rf_div_edge};
   assign rf_vco_tick = ph;
   assign if_vco_tick = ph;
   assign ref_tick = ph;

   // ticks every other cycle so a divider edge, one cycle late, never shares a tick; the if reference edge, two cycles late, does
   always_ff @(posedge core_clk) begin
      if (srst)
         ph <= 1'b0;
      else
         ph <= en & ~ph;
   end

   // ticks per detector period; a tick in the edge cycle opens the next
   always_ff @(posedge core_clk) begin
      for (int i = 0; i < 3; i++) begin
         if (srst) begin
            cnt[i] <= 0;
            num[i] <= 0;
         end else if (e[i]) begin
            rat[i] <= cnt[i];
            cnt[i] <= int'(ph);
            num[i] <= num[i] + 1;
         end else begin
            cnt[i] <= cnt[i] + int'(ph);
         end
      end
   end
endmodule

// ===== testbench/frac_div_core_tb_top.sv
`timescale 1ns/1ps
// drives the core over apb and measures divider periods
module frac_div_core_tb_top;
   typedef struct {
      logic        wr;
      logic [7:0]  a;
      logic [31:0] d;
      logic [31:0] q;
      logic        e;
   } row_t;
   logic        core_clk = 1'b0;
   logic        srst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic        en = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd, keep;
   logic        pready, pslverr, er, rf_vco_tick, if_vco_tick, ref_tick;
   logic        rf_div_edge, if_div_edge, rf_ref_edge, if_ref_edge;
   int          rat [3];
   int          num [3];
   int          rng_on = 0;
   int          rf_seen = 0;
   int          rf_sum = 0;
   int          mismatches = 0;
   int          comparisons = 0;
   int          ref_exp [6] = '{5, 10, 20, 40, 1, 5};
   row_t        rows [14] = '{
      '{1'b0, 8'h00, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h04, 32'h0, 32'h4021, 1'b0},
      '{1'b0, 8'h08, 32'h0, 32'h8000, 1'b0}, '{1'b0, 8'h10, 32'h0, 32'h0, 1'b0},
      '{1'b0, 8'h0C, 32'h0, 32'h0001_0021, 1'b0},
      '{1'b0, 8'h14, 32'h0, 32'h0, 1'b1}, '{1'b1, 8'h04, 32'h5028, 32'h0, 1'b0},
      '{1'b0, 8'h0C, 32'h0, 32'h0001_0021, 1'b0},
      '{1'b1, 8'h00, 32'h0020_0000, 32'h0, 1'b0},
      '{1'b0, 8'h0C, 32'h0, 32'h0001_0028, 1'b0},
      '{1'b1, 8'h0C, 32'h0, 32'h0, 1'b0}, '{1'b1, 8'h14, 32'h1, 32'h0, 1'b1},
      '{1'b0, 8'h0C, 32'h0, 32'h0001_0028, 1'b0},
      '{1'b0, 8'h00, 32'h0, 32'h0020_0000, 1'b0}};

   always #2 core_clk = ~core_clk;

   frac_div_core dut_u (.core_clk(core_clk), .srst(srst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rf_vco_tick(rf_vco_tick), .if_vco_tick(if_vco_tick),
      .ref_tick(ref_tick), .rf_div_edge(rf_div_edge),
      .if_div_edge(if_div_edge), .rf_ref_edge(rf_ref_edge),
      .if_ref_edge(if_ref_edge));
   synth_far_model far_u (.core_clk(core_clk), .srst(srst), .en(en),
      .rf_div_edge(rf_div_edge), .if_div_edge(if_div_edge),
      .if_ref_edge(if_ref_edge), .rf_vco_tick(rf_vco_tick),
      .if_vco_tick(if_vco_tick), .ref_tick(ref_tick), .rat(rat), .num(num));

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic test_done();
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic bail(input string nm);
      mismatches++;
      $display("wrong value %s expected done seen timeout", nm);
      test_done();
   endtask

   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) bail("apb ready");
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // bounded wait for n more edges on detector k
   task automatic wt(input int k, input int n);
      int t0, i;
      t0 = num[k];
      for (i = 0; i < 40000 && num[k] < t0 + n; i++) @(posedge core_clk);
      if (i >= 40000) bail("edge wait");
   endtask

   // each settled rf period must lie within whole-1 to whole+2
   always @(negedge core_clk) begin
      if (rng_on != 0 && num[0] != rf_seen) begin
         chk("rf ratio", 32'(rat[0] >= 39 && rat[0] <= 42), 32'h1);
         rf_sum += rat[0];
      end
      rf_seen = num[0];
   end

   initial begin
      repeat (4) @(posedge core_clk);
      srst <= 1'b0;
      foreach (rows[i]) begin
         apb(rows[i].wr, rows[i].a, rows[i].d);
         chk("slave error", 32'(er), 32'(rows[i].e));
         if (!rows[i].wr) chk("read data", rd, rows[i].q);
      end
      // zero setting with forced lsb: each modulator step adds one
      apb(1'b1, 8'h00, 32'h0);
      en <= 1'b1;
      wt(0, 20);
      en <= 1'b0;
      repeat (8) @(posedge core_clk);
      apb(1'b0, 8'h10, 32'h0);
      chk("acc count", rd, 32'(num[0]));
      // new fraction must not disturb the running accumulator
      keep = rd;
      apb(1'b1, 8'h00, 32'h0020_0000);
      apb(1'b0, 8'h10, 32'h0);
      chk("acc kept", rd, keep);
      en <= 1'b1;
      wt(0, 2);
      rng_on = 1;
      wt(0, 64);
      rng_on = 0;
      chk("rf mean", 32'(rf_sum >= 2589 && rf_sum <= 2595), 32'h1);
      // tap codes 0 to 5 against reference ratio 5 and if ratio 130
      for (int t = 0; t < 6; t++) begin
         apb(1'b1, 8'h08, 32'h8200 | 32'(t));
         wt(2, 3);
         chk("ref ratio", 32'(rat[2]), 32'(ref_exp[t]));
      end
      wt(1, 2);
      chk("if ratio", 32'(rat[1]), 32'h0082);
      // reset in mid-run restores defaults and clears the modulator
      en <= 1'b0;
      repeat (4) @(posedge core_clk);
      srst <= 1'b1;
      repeat (4) @(posedge core_clk);
      srst <= 1'b0;
      apb(1'b0, 8'h0C, 32'h0);
      chk("status", rd, 32'h0001_0021);
      apb(1'b0, 8'h10, 32'h0);
      chk("acc reset", rd, 32'h0);
      apb(1'b0, 8'h08, 32'h0);
      chk("if word reset", rd, 32'h0000_8000);
      apb(1'b0, 8'h04, 32'h0);
      chk("ref word reset", rd, 32'h0000_4021);
      test_done();
   end
endmodule
